// *** src/dps_setting_memory_set.sv ***
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - capture writer supervisor level into bit 31
// - capture writer identity into bits 27-24
// - mid chaining sets chain bit, not final
// - final chaining sets chain bit at end
// - mid irq enable sets pending bit, not final
// - final irq enable sets pending on end
// - interrupt only when pending and mask set
// - six-bit code picks one of 64 bits
// - early mode completes at submit time
// - fifo span codes 0-5, 6-7 reserved
// - static set is never updated after submit
// - dimension picks array or frame per trigger
// - address style increment or constant
// - constant address needs five low zeros
// - incrementing address has no alignment limit
// - zero byte count gives null or dummy
// - zero array or frame count too
// - null or dummy still completes
// - array mode decrements and reloads counts
// - frame mode hands array count onward
// - all-zero set flags missed, keeps pending
// - partly zero set is legal empty move
module dps_setting_memory_set
  import dps_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        wr_supervisor,
  input  wire logic [3:0]  wr_ident,
  input  wire logic        trig_in,
  input  wire logic        req_ready,
  input  wire logic        xfer_done,
  output logic             req_valid,
  output logic [31:0]      req_src,
  output logic [31:0]      req_dst,
  output logic [15:0]      req_bytes,
  output logic [15:0]      req_arrays,
  output logic [2:0]       req_span,
  output logic [1:0]       req_styles,
  output logic             req_align_err,
  output logic [31:0]      reg_rdata,
  output logic             irq_out
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ  = 2'b01,
    ST_WAIT = 2'b10
  } dps_state_e;
  typedef struct packed {
    dps_state_e  st;
    logic [31:0] ctrl;
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] bytes;
    logic [15:0] arrays;
    logic [15:0] frames;
    logic [15:0] reload;
    logic [63:0] mask;
    logic        missed;
    logic        secondary;
    logic        wait_final;
    logic        req_v;
    logic [31:0] r_src;
    logic [31:0] r_dst;
    logic [15:0] r_bytes;
    logic [15:0] r_arr;
    logic [2:0]  r_span;
    logic [1:0]  r_sty;
    logic        r_err;
    logic [31:0] rdata;
    logic        irq;
  } dps_state_s;
  dps_state_s s_q;
  dps_state_s s_d;
  logic        cmp_en;
  logic [5:0]  cmp_idx;
  logic        chain_en;
  logic        pend_en;
  logic [63:0] chain_clr;
  logic [63:0] pend_clr;
  logic [63:0] chain_bits;
  logic [63:0] pend_bits;
  logic        cmp_final;
  logic        is_final;
  logic        all_zero;
  logic        any_zero;
  logic        wr_hit;
  // ---------------------------------------------------------------
  // completion vectors
  // ---------------------------------------------------------------
  dps_bitset #(.N(CODES)) u_chain (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .set_en   (chain_en),
    .set_idx  (cmp_idx),
    .clr_bits (chain_clr),
    .bits_q   (chain_bits)
  );
  dps_bitset #(.N(CODES)) u_pend (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .set_en   (pend_en),
    .set_idx  (cmp_idx),
    .clr_bits (pend_clr),
    .bits_q   (pend_bits)
  );
  // count state decode
  assign all_zero = (s_q.bytes == CNT_ZERO) && (s_q.arrays == CNT_ZERO)
                    && (s_q.frames == CNT_ZERO);
  assign any_zero = (s_q.bytes == CNT_ZERO) || (s_q.arrays == CNT_ZERO)
                    || (s_q.frames == CNT_ZERO);
  // last request of the set: frame mode last frame, array mode last array
  assign is_final = s_q.ctrl[DIM_BIT] ? (s_q.frames == CNT_ONE)
                    : ((s_q.frames == CNT_ONE) && (s_q.arrays == CNT_ONE));
  assign wr_hit = reg_wr && ((reg_addr == ADDR_CTRL) ||
                  (reg_addr == ADDR_SRC) || (reg_addr == ADDR_COUNTS) ||
                  (reg_addr == ADDR_DST) || (reg_addr == ADDR_RELOAD) ||
                  (reg_addr == ADDR_FRAMES));

  // ---------------------------------------------------------------
  // completion event routing
  // ---------------------------------------------------------------
  always_comb
  begin
    cmp_en    = 1'b0;
    cmp_final = 1'b0;
    if ((s_q.st == ST_REQ && s_q.req_v && req_ready && s_q.ctrl[EARLY_BIT])
        || (s_q.st == ST_WAIT && xfer_done))
    begin
      cmp_en    = 1'b1;
      cmp_final = s_q.wait_final;
    end
    // null or dummy completes at once
    else if (s_q.st == ST_IDLE && trig_in && !s_q.secondary && any_zero)
    begin
      cmp_en    = 1'b1;
      cmp_final = 1'b1;
    end
  end
  assign cmp_idx = s_q.ctrl[CODE_HI:CODE_LO];
  assign chain_en = cmp_en && (cmp_final ? s_q.ctrl[FCHAIN_BIT]
                                         : s_q.ctrl[MCHAIN_BIT]);
  assign pend_en = cmp_en && (cmp_final ? s_q.ctrl[FIRQ_BIT]
                                        : s_q.ctrl[MIRQ_BIT]);
  // write-one-to-clear decode for the vectors
  assign chain_clr = {(reg_wr && reg_addr == ADDR_CHAIN_HI) ? reg_wdata
                                                            : WORD_ZERO,
                      (reg_wr && reg_addr == ADDR_CHAIN_LO) ? reg_wdata
                                                            : WORD_ZERO};
  assign pend_clr  = {(reg_wr && reg_addr == ADDR_PEND_HI) ? reg_wdata
                                                           : WORD_ZERO,
                      (reg_wr && reg_addr == ADDR_PEND_LO) ? reg_wdata
                                                           : WORD_ZERO};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    // parameter word, mask and status writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        ADDR_CTRL:
          s_d.ctrl = (reg_wdata & CTRL_WMASK) | (s_q.ctrl & ~CTRL_WMASK);
        ADDR_SRC:    s_d.src = reg_wdata;
        ADDR_DST:    s_d.dst = reg_wdata;
        ADDR_COUNTS:
        begin
          s_d.arrays = reg_wdata[31:16];
          s_d.bytes  = reg_wdata[15:0];
        end
        ADDR_RELOAD: s_d.reload = reg_wdata[31:16];
        ADDR_FRAMES: s_d.frames = reg_wdata[15:0];
        ADDR_MASK_LO: s_d.mask[31:0] = reg_wdata;
        ADDR_MASK_HI: s_d.mask[63:32] = reg_wdata;
        ADDR_STATUS:
        begin
          // write one clears missed and secondary flags
          s_d.missed    = s_q.missed && !reg_wdata[0];
          s_d.secondary = s_q.secondary && !reg_wdata[1];
        end
        default: ;
      endcase
    end
    // supervisor capture on any parameter word write (not mask, status, chain or pending)
    // identity capture on any parameter word write (not mask, status, chain or pending)
    if (wr_hit)
    begin
      s_d.ctrl[SUP_BIT]          = wr_supervisor;
      s_d.ctrl[IDENT_HI:IDENT_LO] = wr_ident;
    end
    unique case (s_q.st)
      ST_IDLE:
      begin
        if (trig_in && !s_q.secondary)
        begin
          if (all_zero)
          begin
            // null set flags missed, holds secondary
            s_d.missed    = 1'b1;
            s_d.secondary = 1'b1;
          end
          else if (any_zero)
            // dummy set is a legal empty move
            s_d.secondary = 1'b0;
          else
          begin
            // only nonzero counts reach the engine
            // array and frame counts nonzero here
            s_d.req_v   = 1'b1;
            s_d.r_src   = s_q.src;
            s_d.r_dst   = s_q.dst;
            s_d.r_bytes = s_q.bytes;
            // frame mode sends full array count
            // engine counts arrays in frame mode
            s_d.r_arr   = s_q.ctrl[DIM_BIT] ? s_q.arrays : CNT_ONE;
            // span code forwarded, reserved codes flagged only with a constant address style
            s_d.r_span  = s_q.ctrl[SPAN_HI:SPAN_LO];
            s_d.r_sty   = {s_q.ctrl[WSTYLE_BIT], s_q.ctrl[RSTYLE_BIT]};
            s_d.r_err   = (s_q.ctrl[RSTYLE_BIT] &&
                           s_q.src[ALIGN_BITS-1:0] != ALIGN_ZERO) ||
                          (s_q.ctrl[WSTYLE_BIT] &&
                           s_q.dst[ALIGN_BITS-1:0] != ALIGN_ZERO) ||
                          ((s_q.ctrl[WSTYLE_BIT] || s_q.ctrl[RSTYLE_BIT]) &&
                           s_q.ctrl[SPAN_HI:SPAN_LO] > SPAN_MAX);
            s_d.wait_final = is_final;
            s_d.st = ST_REQ;
          end
        end
      end
      ST_REQ:
      begin
        if (req_ready)
        begin
          s_d.req_v = 1'b0;
          s_d.st = s_q.ctrl[EARLY_BIT] ? ST_IDLE : ST_WAIT;
          if (!s_q.ctrl[STATIC_BIT])
          begin
            if (s_q.ctrl[DIM_BIT])
              s_d.frames = s_q.frames - CNT_ONE;
            else if (s_q.arrays == CNT_ONE)
            begin
              s_d.arrays = s_q.reload;
              s_d.frames = s_q.frames - CNT_ONE;
            end
            else
              s_d.arrays = s_q.arrays - CNT_ONE;
          end
        end
      end
      ST_WAIT:
        if (xfer_done)
          s_d.st = ST_IDLE;
      default: s_d.st = ST_IDLE;
    endcase
    s_d.irq = |(pend_bits & s_q.mask);
    // read data one cycle after strobe
    s_d.rdata = WORD_ZERO;
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_CTRL:     s_d.rdata = s_q.ctrl;
        ADDR_SRC:      s_d.rdata = s_q.src;
        ADDR_DST:      s_d.rdata = s_q.dst;
        ADDR_COUNTS:   s_d.rdata = {s_q.arrays, s_q.bytes};
        ADDR_RELOAD:   s_d.rdata = {s_q.reload, CNT_ZERO};
        ADDR_FRAMES:   s_d.rdata = {CNT_ZERO, s_q.frames};
        ADDR_CHAIN_LO: s_d.rdata = chain_bits[31:0];
        ADDR_CHAIN_HI: s_d.rdata = chain_bits[63:32];
        ADDR_PEND_LO:  s_d.rdata = pend_bits[31:0];
        ADDR_PEND_HI:  s_d.rdata = pend_bits[63:32];
        ADDR_MASK_LO:  s_d.rdata = s_q.mask[31:0];
        ADDR_MASK_HI:  s_d.rdata = s_q.mask[63:32];
        ADDR_STATUS:   s_d.rdata = {28'h0000000, s_q.st, s_q.secondary,
                                    s_q.missed};
        default:       s_d.rdata = WORD_ZERO;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end
  // outputs straight from flops
  assign req_valid     = s_q.req_v;
  assign req_src       = s_q.r_src;
  assign req_dst       = s_q.r_dst;
  assign req_bytes     = s_q.r_bytes;
  assign req_arrays    = s_q.r_arr;
  assign req_span      = s_q.r_span;
  assign req_styles    = s_q.r_sty;
  assign req_align_err = s_q.r_err;
  assign reg_rdata     = s_q.rdata;
  assign irq_out       = s_q.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence submit_s;
    s_q.st == ST_REQ && s_q.req_v && req_ready;
  endsequence
  sup_capture_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_hit |=> s_q.ctrl[SUP_BIT] == $past(wr_supervisor))
    else $error("supervisor bit not captured");
  ident_capture_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_hit |=> s_q.ctrl[IDENT_HI:IDENT_LO] == $past(wr_ident))
    else $error("identity not captured");
  final_chain_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cmp_en && cmp_final && s_q.ctrl[FCHAIN_BIT]) |=> chain_bits[$past(cmp_idx)])
    else $error("final chain bit missing");
  mid_chain_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cmp_en && !cmp_final && s_q.ctrl[MCHAIN_BIT]) |=>
      chain_bits[$past(cmp_idx)])
    else $error("mid chain bit missing");
  final_pend_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cmp_en && cmp_final && s_q.ctrl[FIRQ_BIT]) |=> pend_bits[$past(cmp_idx)])
    else $error("final pending bit missing");
  irq_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 irq_out == |($past(pend_bits) & $past(s_q.mask)))
    else $error("irq not masked pending");
  static_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (submit_s and s_q.ctrl[STATIC_BIT] && !reg_wr) |=>
      $stable(s_q.frames) && $stable(s_q.arrays))
    else $error("static set updated");
  reload_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (submit_s and !s_q.ctrl[STATIC_BIT] && !s_q.ctrl[DIM_BIT] &&
     s_q.arrays == CNT_ONE && !reg_wr) |=>
      s_q.arrays == $past(s_q.reload) &&
      s_q.frames == $past(s_q.frames) - CNT_ONE)
    else $error("array reload wrong");
  null_missed_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_q.st == ST_IDLE && trig_in && !s_q.secondary && all_zero) |=>
      s_q.missed && s_q.secondary && !req_valid)
    else $error("null set not flagged");
  align_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (req_valid && !req_styles[0] && !req_styles[1]) |-> !req_align_err)
    else $error("increment style flagged");
endmodule // dps_setting_memory_set
`default_nettype wire

// *** src/dps_pkg.sv ***
package dps_pkg;
  // register offsets (byte addresses of the parameter words, trigger, vectors, mask and status)
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_SRC      = 8'h04;
  localparam logic [7:0] ADDR_COUNTS   = 8'h08;
  localparam logic [7:0] ADDR_DST      = 8'h0C;
  localparam logic [7:0] ADDR_RELOAD   = 8'h14;
  localparam logic [7:0] ADDR_FRAMES   = 8'h1C;
  localparam logic [7:0] ADDR_TRIG     = 8'h20;
  localparam logic [7:0] ADDR_CHAIN_LO = 8'h24;
  localparam logic [7:0] ADDR_CHAIN_HI = 8'h28;
  localparam logic [7:0] ADDR_PEND_LO  = 8'h2C;
  localparam logic [7:0] ADDR_PEND_HI  = 8'h30;
  localparam logic [7:0] ADDR_MASK_LO  = 8'h34;
  localparam logic [7:0] ADDR_MASK_HI  = 8'h38;
  localparam logic [7:0] ADDR_STATUS   = 8'h3C;
  // control word field positions
  localparam int SUP_BIT     = 31;
  localparam int IDENT_HI    = 27;
  localparam int IDENT_LO    = 24;
  localparam int MCHAIN_BIT  = 23;
  localparam int FCHAIN_BIT  = 22;
  localparam int MIRQ_BIT    = 21;
  localparam int FIRQ_BIT    = 20;
  localparam int CODE_HI     = 17;
  localparam int CODE_LO     = 12;
  localparam int EARLY_BIT   = 11;
  localparam int SPAN_HI     = 10;
  localparam int SPAN_LO     = 8;
  localparam int STATIC_BIT  = 3;
  localparam int DIM_BIT     = 2;
  localparam int WSTYLE_BIT  = 1;
  localparam int RSTYLE_BIT  = 0;
  // writable control bits (reserved ranges and capture bits read as stored)
  localparam logic [31:0] CTRL_WMASK  = 32'h00F3_FF0F;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
  localparam logic [15:0] CNT_ZERO    = 16'h0000;
  localparam logic [15:0] CNT_ONE     = 16'h0001;
  localparam logic [4:0]  ALIGN_ZERO  = 5'h00;
  localparam int          ALIGN_BITS  = 5;
  localparam logic [2:0]  SPAN_MAX    = 3'h5;
  localparam int          CODES       = 64;
endpackage : dps_pkg

// *** src/dps_bitset.sv ***
`timescale 1ns/1ns
`default_nettype none
// 64-entry sticky vector: hardware set wins over software clear
module dps_bitset
  import dps_pkg::*;
#(
  parameter int N = 64
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         set_en,
  input  wire logic [5:0]   set_idx,
  input  wire logic [N-1:0] clr_bits,
  output logic      [N-1:0] bits_q
);
  typedef struct packed { logic [N-1:0] v; } dps_bits_s;
  dps_bits_s s_q;
  dps_bits_s s_d;

  // per-bit set/clear
  always_comb
  begin
    s_d = s_q;
    for (int i = 0; i < N; i++)
    begin
      if (set_en && (set_idx == 6'(i)))
        s_d.v[i] = 1'b1;
      else if (clr_bits[i])
        s_d.v[i] = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign bits_q = s_q.v;
endmodule // dps_bitset
`default_nettype wire

// *** dv/dps_engine_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// transfer engine stand-in: stalls when slow, reports moved data
module dps_engine_model (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic slow,
  input  wire logic req_valid,
  output logic      req_ready,
  output logic      xfer_done,
  output int        acc_count,
  output int        done_count
);
  int stall_q;
  int busy_q;

  // accept a request, then pulse done three cycles later
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_ready  <= 1'b0;
      xfer_done  <= 1'b0;
      acc_count  <= 0;
      done_count <= 0;
      stall_q    <= 0;
      busy_q     <= 0;
    end
    else
    begin
      xfer_done <= (busy_q == 1);
      if (busy_q == 1)
        done_count <= done_count + 1;
      if (busy_q > 0)
        busy_q <= busy_q - 1;
      if (req_valid && req_ready)
      begin
        req_ready <= 1'b0;
        acc_count <= acc_count + 1;
        busy_q    <= 3;
        stall_q   <= slow ? 4 : 0;
      end
      else if (req_valid && busy_q == 0 && stall_q > 0)
        stall_q <= stall_q - 1;  // slow answer
      else if (req_valid && busy_q == 0)
        req_ready <= 1'b1;
    end
  end
endmodule // dps_engine_model
`default_nettype wire

// *** dv/test_dps_setting_memory_set_field_logic.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  fail_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
  $time, (g), (e)); end end
module test_dps_setting_memory_set_field_logic;
  import dps_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, wr_supervisor = 1'b0;
  logic [3:0]  wr_ident = 4'h0;
  logic        trig_in = 1'b0, slow = 1'b0;
  logic        req_valid, req_align_err, irq_out, req_ready, xfer_done;
  logic [31:0] req_src, req_dst, reg_rdata, rv, c, m_ctrl, m_src, m_dst;
  logic [31:0] seed = 32'hE898;
  logic [15:0] req_bytes, req_arrays, m_b, m_a, m_f, m_r;
  logic [2:0]  req_span;
  logic [1:0]  req_styles;
  logic [63:0] mask, got;
  logic [3:0]  last_id;
  logic        last_sup, fin;
  int          fail_count = 0, samples_checked = 0, acc_count, done_count;

  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  dps_setting_memory_set dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .wr_supervisor(wr_supervisor), .wr_ident(wr_ident),
    .trig_in(trig_in), .req_ready(req_ready), .xfer_done(xfer_done),
    .req_valid(req_valid), .req_src(req_src), .req_dst(req_dst),
    .req_bytes(req_bytes), .req_arrays(req_arrays),
    .req_span(req_span), .req_styles(req_styles),
    .req_align_err(req_align_err), .reg_rdata(reg_rdata),
    .irq_out(irq_out)
  );

  dps_engine_model engine (
    .sys_clk(sys_clk), .rst_n(rst_n), .slow(slow),
    .req_valid(req_valid), .req_ready(req_ready),
    .xfer_done(xfer_done), .acc_count(acc_count),
    .done_count(done_count)
  );

  // ----------------------------------------
  // bus and sequencing tasks
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic end_sim;
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // one write cycle with a random writer identity
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    seed = lfsr(seed);
    last_sup = seed[0];
    last_id = seed[7:4];
    reg_addr <= a;
    reg_wdata <= d;
    wr_supervisor <= last_sup;
    wr_ident <= last_id;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  // one read cycle, data sampled in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    @(posedge sys_clk);
  endtask

  task automatic rd64(input logic [7:0] a, output logic [63:0] v);
    logic [31:0] lo;
    logic [31:0] hi;
    rd(a, lo);
    rd(a + 8'h04, hi);
    v = {hi, lo};
  endtask

  // program a whole set and check the captured control word
  task automatic setup(input logic [31:0] cw,
                       input logic [15:0] b, a, f, r);
    seed = lfsr(seed);
    m_src = seed;
    seed = lfsr(seed);
    m_dst = seed;
    m_b = b;
    m_a = a;
    m_f = f;
    m_r = r;
    wr(ADDR_CTRL, cw & CTRL_WMASK);
    wr(ADDR_SRC, m_src);
    wr(ADDR_DST, m_dst);
    wr(ADDR_COUNTS, {a, b});
    wr(ADDR_RELOAD, {r, CNT_ZERO});
    wr(ADDR_FRAMES, {CNT_ZERO, f});
    m_ctrl = (cw & CTRL_WMASK) | {last_sup, 3'h0, last_id, 24'h0};
    rd(ADDR_CTRL, rv);
    `CHK(rv, m_ctrl)
    seed = lfsr(seed);
    mask = {seed, lfsr(seed)};
    wr(ADDR_MASK_LO, mask[31:0]);
    wr(ADDR_MASK_HI, mask[63:32]);
    rd64(ADDR_MASK_LO, got);
    `CHK(got, mask)
  endtask

  // one trigger; want: a request expected, comp: completion expected
  task automatic fire(input logic want, input logic comp);
    int oa;
    int od;
    int n;
    logic ae;
    logic [63:0] ec;
    logic [63:0] ep;
    oa = acc_count;
    od = done_count;
    ae = (m_ctrl[RSTYLE_BIT] && m_src[4:0] != ALIGN_ZERO) ||
         (m_ctrl[WSTYLE_BIT] && m_dst[4:0] != ALIGN_ZERO) ||
         ((m_ctrl[WSTYLE_BIT] || m_ctrl[RSTYLE_BIT]) &&
          m_ctrl[SPAN_HI:SPAN_LO] > SPAN_MAX);
    n = 0;
    trig_in <= 1'b1;
    @(posedge sys_clk);
    trig_in <= 1'b0;
    #1;
    while (want && req_valid !== 1'b1 && n < 60)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    `CHK(req_valid, want)
    if (want)
    begin
      `CHK(req_src, m_src)
      `CHK(req_dst, m_dst)
      `CHK(req_bytes, m_b)
      `CHK(req_arrays, m_ctrl[DIM_BIT] ? m_a : CNT_ONE)
      `CHK(req_span, m_ctrl[SPAN_HI:SPAN_LO])
      `CHK(req_styles, m_ctrl[1:0])
      `CHK(req_align_err, ae)
    end
    while (want && acc_count == oa && n < 60)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    fin = !want || (m_f == CNT_ONE && (m_ctrl[DIM_BIT] || m_a == CNT_ONE));
    ec = 64'h1 << m_ctrl[CODE_HI:CODE_LO];
    ep = ec;
    if (!comp || !m_ctrl[fin ? FCHAIN_BIT : MCHAIN_BIT])
      ec = 64'h0;
    if (!comp || !m_ctrl[fin ? FIRQ_BIT : MIRQ_BIT])
      ep = 64'h0;
    // early completion shows before the data has moved
    if (want)
    begin
      rd64(ADDR_CHAIN_LO, got);
      `CHK(got, m_ctrl[EARLY_BIT] ? ec : 64'h0)
    end
    while (want && !m_ctrl[EARLY_BIT] && done_count == od && n < 60)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 60)
    begin
      fail_count++;
      end_sim;
    end
    repeat (4) @(posedge sys_clk);
    `CHK(acc_count, want ? oa + 1 : oa)
    if (want && !m_ctrl[STATIC_BIT] && m_ctrl[DIM_BIT])
      m_f = m_f - 16'h1;
    else if (want && !m_ctrl[STATIC_BIT])
    begin
      m_a = m_a - 16'h1;
      if (m_a == CNT_ZERO)
      begin
        m_f = m_f - 16'h1;
        m_a = m_r;
      end
    end
    rd64(ADDR_CHAIN_LO, got);
    `CHK(got, ec)
    rd64(ADDR_PEND_LO, got);
    `CHK(got, ep)
    `CHK(irq_out, |(ep & mask))
    wr(ADDR_CHAIN_LO, 32'hFFFF_FFFF);
    wr(ADDR_CHAIN_HI, 32'hFFFF_FFFF);
    wr(ADDR_PEND_LO, 32'hFFFF_FFFF);
    wr(ADDR_PEND_HI, 32'hFFFF_FFFF);
    if (!fin || m_ctrl[STATIC_BIT])
    begin
      rd(ADDR_COUNTS, rv);
      `CHK(rv, {m_a, m_b})
      rd(ADDR_FRAMES, rv);
      `CHK(rv[15:0], m_f)
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    `CHK(irq_out, 1'b0)
    rd(8'h40, rv);
    `CHK(rv, WORD_ZERO)
    // every span code, both dimensions, both completion points
    for (int k = 0; k < 8; k++)
    begin
      seed = lfsr(seed);
      slow <= seed[9];
      c = seed;
      c[EARLY_BIT] = k[0];
      c[DIM_BIT] = k[1];
      c[STATIC_BIT] = 1'b0;
      c[SPAN_HI:SPAN_LO] = k[2:0];
      setup(c, seed[15:0] | CNT_ONE, 16'h2, 16'h2, 16'h3);
      fin = 1'b0;
      for (int t = 0; t < 8 && !fin; t++)
        fire(1'b1, 1'b1);
    end
    // static only for a lone single-frame set
    c = lfsr(seed);
    c[STATIC_BIT] = 1'b1;
    c[DIM_BIT] = 1'b1;
    setup(c, 16'h10, 16'h4, CNT_ONE, CNT_ZERO);
    fire(1'b1, 1'b1);
    fire(1'b1, 1'b1);
    // all counts zero: flagged, further triggers dropped
    setup(lfsr(c), CNT_ZERO, CNT_ZERO, CNT_ZERO, CNT_ZERO);
    fire(1'b0, 1'b1);
    rd(ADDR_STATUS, rv);
    `CHK(rv[1:0], 2'h3)
    fire(1'b0, 1'b0);
    wr(ADDR_STATUS, 32'h3);
    rd(ADDR_STATUS, rv);
    `CHK(rv[1:0], 2'h0)
    // one count zero: empty move, still serviced
    setup(lfsr(seed), CNT_ZERO, 16'h5, CNT_ONE, CNT_ZERO);
    fire(1'b0, 1'b1);
    rd(ADDR_STATUS, rv);
    `CHK(rv[1:0], 2'h0)
    fire(1'b0, 1'b1);
    end_sim;
  end

  // hang guard
  initial
  begin
    #(50 * 60000);
    fail_count++;
    end_sim;
  end
endmodule // test_dps_setting_memory_set_field_logic
`default_nettype wire
